// [verilog/dmt_defines.svh]
// Purpose: Constants for the monitor mux and toggle control block
// Assumes: 32-bit serial frames, command byte first, MSB first
// Notes:   Offsets, fields, reset values and command codes
// Function
// [R1] Monitor pin undriven while enable bit clear
// [R2] Mux register written by dedicated command
// [R3] Reset clears enable and select code
// [R4] Mux readback shifts out next frame
// [R5] Bit 8 picks voltage, else sense; code gives the reference low pin when bit 9 is set and bits 5:4 are zero
// [R6] Bits 5:4 pick supply, reference, temperature
// [R7] Each channel toggle or dither independently
// [R8] Toggle clock selects register A or B
// [R9] Toggle clock from three pins or software
// [R10] Clock high gives A, low gives B
// [R11] Zero enable register stops all toggling
// [R12] Select 11 pin two, 10 pin one
// [R13] One enable bit per channel
// [R14] Output follows both toggle clock edges
// [R15] Toggle pins synchronised before use
`ifndef DMT_DEFINES_SVH
`define DMT_DEFINES_SVH

`define DMT_FRAME_BITS     6'h20
`define DMT_CMD_WRITE_CODE 4'h0
`define DMT_CMD_CHAN_SET   4'h1
`define DMT_CMD_AB_SELECT  8'h90
`define DMT_CMD_TD_ENABLE  8'hb0
`define DMT_CMD_SW_TOGGLE  8'hc0
`define DMT_CMD_MUX_WRITE  8'h75
`define DMT_CMD_MUX_READ   8'hd0

`define DMT_MUX_EN_BIT     10
`define DMT_MUX_VOLT_BIT   8
`define DMT_MUX_REFERENCE_LOW_PIN_BIT   9
`define DMT_MUX_RESET      11'h000
`define DMT_CHSET_MODE_BIT 6
`define DMT_CHSET_SEL_LSB  4

`define DMT_TD_SEL_PIN2    2'h3
`define DMT_TD_SEL_PIN1    2'h2
`define DMT_TD_SEL_PIN0    2'h1
`define DMT_TD_SEL_SW      2'h0

`endif

// [verilog/dmt_pkg.sv]
// Purpose: Types for the monitor mux and toggle control block
// Assumes: One-hot codes throughout
// Notes:   Constants live in the defines header
package dmt_pkg;

  typedef enum logic [1:0] {
    DMT_IDLE  = 2'b01,
    DMT_SHIFT = 2'b10
  } dmt_frame_t;

  typedef enum logic [5:0] {
    DMT_SRC_VOLT   = 6'b000001,
    DMT_SRC_SENSE  = 6'b000010,
    DMT_SRC_REFERENCE_LOW_PIN   = 6'b000100,
    DMT_SRC_SUPPLY = 6'b001000,
    DMT_SRC_REF    = 6'b010000,
    DMT_SRC_TEMP   = 6'b100000
  } dmt_src_t;

endpackage

// [verilog/dmt_toggle_chan.sv]
// Purpose: One channel of A/B toggle selection into the DAC register
// Assumes: Toggle pins already synchronised to clock
// Notes:   Dither mode holds code A; sample generator lives elsewhere
`timescale 1ns/1ps
`include "dmt_defines.svh"

module dmt_toggle_chan (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [2:0]  toggle_sync,
  input  wire logic        sw_toggle,
  input  wire logic [1:0]  toggle_source_select,
  input  wire logic        dither_mode,
  input  wire logic        enable,
  input  wire logic [15:0] code_a,
  input  wire logic [15:0] code_b,
  output logic      [15:0] dac_code
);

  logic tck;
  logic use_b;

  assign tck = (toggle_source_select == `DMT_TD_SEL_PIN2) ? toggle_sync[2] :   // [R12]
               (toggle_source_select == `DMT_TD_SEL_PIN1) ? toggle_sync[1] :   // [R12]
               (toggle_source_select == `DMT_TD_SEL_PIN0) ? toggle_sync[0] :   // [R9]
               sw_toggle;                                                      // [R9]
  // Level follow gives an update on both edges
  assign use_b = enable && !dither_mode && !tck;                               // [R7] [R10] [R11] [R14]

  always_ff @(posedge clock) begin
    if (rst) begin
      dac_code <= 16'h0000;
    end else begin
      dac_code <= use_b ? code_b : code_a;                                     // [R8] [R10]
    end
  end

endmodule

// [verilog/dmt_top.sv]
// Purpose: Serial command slave, monitor mux control and eight toggle channels
// Assumes: Serial clock well below clock rate; mode 0, sample on rising edge
// Notes:   Frames that are not exactly 32 bits are dropped
`timescale 1ns/1ps
`include "dmt_defines.svh"

module dmt_top (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             sclk,
  input  wire logic             cs_n,
  input  wire logic             sdi,
  input  wire logic [2:0]       toggle_pins,
  output logic                  sdo,
  output logic                  monitor_output_enable,
  output logic [5:0]            monitor_source,
  output logic [2:0]            monitor_channel,
  output logic [7:0][15:0]      dac_code
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [5:0] sync3;

  always_ff @(posedge clock) begin
    if (rst) begin
      // Preset to idle levels: cs_n high, sclk low, so no false edge
      sync1 <= 6'h10;
      sync2 <= 6'h10;
      sync3 <= 6'h10;
    end else begin
      sync1 <= {sclk, cs_n, sdi, toggle_pins};                                 // [R15]
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       cs_rise;
  logic       sdi_s;
  logic [2:0] toggle_sync;

  assign sclk_rise   = sync2[5] && !sync3[5];
  assign sclk_fall   = !sync2[5] && sync3[5];
  assign cs_fall     = !sync2[4] && sync3[4];
  assign cs_rise     = sync2[4] && !sync3[4];
  assign sdi_s       = sync2[3];
  assign toggle_sync = sync2[2:0];                                             // [R15]

  ////////////////////////////////////////////////////////////////////////
  // Frame shifter

  dmt_pkg::dmt_frame_t state;
  dmt_pkg::dmt_frame_t next_state;
  logic [31:0] rx_shift;
  logic [31:0] tx_shift;
  logic [5:0]  bit_count;
  logic [15:0] read_buffer;

  assign next_state = (state == dmt_pkg::DMT_IDLE && cs_fall) ? dmt_pkg::DMT_SHIFT :
                      (state == dmt_pkg::DMT_SHIFT && cs_rise) ? dmt_pkg::DMT_IDLE : state;

  logic frame_done;
  logic [7:0]  cmd;
  logic [15:0] data;

  assign frame_done = (state == dmt_pkg::DMT_SHIFT) && cs_rise && (bit_count == `DMT_FRAME_BITS);
  assign cmd        = rx_shift[31:24];
  assign data       = rx_shift[23:8];

  always_ff @(posedge clock) begin
    if (rst) begin
      state     <= dmt_pkg::DMT_IDLE;
      rx_shift  <= 32'h00000000;
      tx_shift  <= 32'h00000000;
      bit_count <= 6'h00;
    end else begin
      state <= next_state;
      case (state)
        dmt_pkg::DMT_IDLE: begin
          bit_count <= 6'h00;
          // Readback word was captured by the previous frame
          if (cs_fall) begin
            tx_shift <= {8'h00, read_buffer, 8'h00};                           // [R4]
          end
        end
        dmt_pkg::DMT_SHIFT: begin
          if (sclk_rise) begin
            rx_shift <= {rx_shift[30:0], sdi_s};
            if (bit_count != 6'h3f) begin
              bit_count <= bit_count + 6'h01;
            end
          end
          if (sclk_fall) begin
            tx_shift <= {tx_shift[30:0], 1'b0};
          end
        end
        default: begin
          bit_count <= 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sdo <= 1'b0;
    end else begin
      sdo <= tx_shift[31];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode and registers

  logic        wr_code;
  logic        wr_chset;
  logic        wr_ab;
  logic        wr_en;
  logic        wr_sw;
  logic        wr_mux;
  logic        rd_mux;
  logic [2:0]  addr;

  assign addr     = cmd[2:0];
  assign wr_code  = frame_done && (cmd[7:4] == `DMT_CMD_WRITE_CODE) && !cmd[3];
  assign wr_chset = frame_done && (cmd[7:4] == `DMT_CMD_CHAN_SET) && !cmd[3];
  assign wr_ab    = frame_done && (cmd == `DMT_CMD_AB_SELECT);
  assign wr_en    = frame_done && (cmd == `DMT_CMD_TD_ENABLE);
  assign wr_sw    = frame_done && (cmd == `DMT_CMD_SW_TOGGLE);
  assign wr_mux   = frame_done && (cmd == `DMT_CMD_MUX_WRITE);                 // [R2]
  assign rd_mux   = frame_done && (cmd == `DMT_CMD_MUX_READ);                  // [R4]

  logic [10:0]     monitor_mux_control;
  logic [7:0]      ab_select;
  logic [15:0]     toggle_enable;
  logic            sw_toggle;
  logic [7:0][15:0] code_a;
  logic [7:0][15:0] code_b;
  logic [7:0][1:0]  toggle_source_select;
  logic [7:0]       dither_mode;

  always_ff @(posedge clock) begin
    if (rst) begin
      monitor_mux_control <= `DMT_MUX_RESET;                                   // [R3]
      ab_select           <= 8'h00;
      toggle_enable       <= 16'h0000;
      sw_toggle           <= 1'b0;
      read_buffer         <= 16'h0000;
    end else begin
      if (wr_mux) begin
        monitor_mux_control <= data[10:0];                                     // [R2]
      end
      if (wr_ab) begin
        ab_select <= data[7:0];
      end
      if (wr_en) begin
        toggle_enable <= data;                                                 // [R11] [R13]
      end
      if (wr_sw) begin
        sw_toggle <= data[0];
      end
      // Any other frame leaves a zero word for the next one
      if (frame_done) begin
        read_buffer <= rd_mux ? {5'h00, monitor_mux_control} : 16'h0000;       // [R4]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      code_a               <= '0;
      code_b               <= '0;
      toggle_source_select <= '0;
      dither_mode          <= 8'h00;
    end else begin
      if (wr_code && !ab_select[addr]) begin
        code_a[addr] <= data;
      end
      if (wr_code && ab_select[addr]) begin
        code_b[addr] <= data;
      end
      if (wr_chset) begin
        toggle_source_select[addr] <= data[`DMT_CHSET_SEL_LSB +: 2];           // [R9]
        dither_mode[addr]          <= data[`DMT_CHSET_MODE_BIT];               // [R7]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Monitor mux routing

  logic [9:0]        msel;
  dmt_pkg::dmt_src_t next_source;

  assign msel = monitor_mux_control[9:0];
  assign next_source =
    msel[`DMT_MUX_VOLT_BIT] ? dmt_pkg::DMT_SRC_VOLT :                          // [R5]
    (msel[5:4] == 2'h3)     ? dmt_pkg::DMT_SRC_TEMP :                          // [R6]
    (msel[5:4] == 2'h2)     ? dmt_pkg::DMT_SRC_REF :                           // [R6]
    (msel[5:4] == 2'h1)     ? dmt_pkg::DMT_SRC_SUPPLY :                        // [R6]
    msel[`DMT_MUX_REFERENCE_LOW_PIN_BIT] ? dmt_pkg::DMT_SRC_REFERENCE_LOW_PIN :
    dmt_pkg::DMT_SRC_SENSE;                                                    // [R5]

  always_ff @(posedge clock) begin
    if (rst) begin
      monitor_output_enable <= 1'b0;                                           // [R1]
      monitor_source        <= dmt_pkg::DMT_SRC_SENSE;
      monitor_channel       <= 3'h0;
    end else begin
      monitor_output_enable <= monitor_mux_control[`DMT_MUX_EN_BIT];           // [R1]
      monitor_source        <= next_source;
      monitor_channel       <= msel[3:1];                                      // [R5]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Toggle channels

  for (genvar ch = 0; ch < 8; ch++) begin : g_chan
    dmt_toggle_chan u_chan (
      .clock                (clock),
      .rst                  (rst),
      .toggle_sync          (toggle_sync),
      .sw_toggle            (sw_toggle),
      .toggle_source_select (toggle_source_select[ch]),
      .dither_mode          (dither_mode[ch]),
      .enable               (toggle_enable[ch]),                               // [R13]
      .code_a               (code_a[ch]),
      .code_b               (code_b[ch]),
      .dac_code             (dac_code[ch])
    );
  end

endmodule

// [sim/dmt_props.sv]
// Purpose: Port checker for the monitor mux and toggle block
// Assumes: Frames execute a few clocks after cs_n rises
// Notes:   Quiet windows are long enough to cover sync delays
`timescale 1ns/1ps
module dmt_props (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             sclk,
  input  wire logic             cs_n,
  input  wire logic [2:0]       toggle_pins,
  input  wire logic             sdo,
  input  wire logic             monitor_output_enable,
  input  wire logic [5:0]       monitor_source,
  input  wire logic [2:0]       monitor_channel,
  input  wire logic [7:0][15:0] dac_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  sequence s_pins_idle;
    ($stable(toggle_pins) && cs_n && $past(cs_n, 4))[*8];
  endsequence
  sequence s_link_idle;
    (cs_n && $past(cs_n, 4) && !sclk)[*8];
  endsequence
  property p_rst_mon;
    $fell(rst) |-> !monitor_output_enable && monitor_source == 6'h02 && monitor_channel == 3'h0;
  endproperty
  property p_rst_dac;
    $fell(rst) |-> dac_code == '0;
  endproperty
  property p_onehot;
    $onehot(monitor_source);
  endproperty
  // Mux outputs only move once a frame has closed
  property p_src_frame;
    $changed(monitor_source) |-> $past(cs_n, 1) && $past(cs_n, 4);
  endproperty
  property p_oe_frame;
    $changed(monitor_output_enable) |-> $past(cs_n, 1) && $past(cs_n, 4);
  endproperty
  property p_ch_frame;
    $changed(monitor_channel) |-> $past(cs_n, 1) && $past(cs_n, 4);
  endproperty
  property p_dac_quiet;
    s_pins_idle |-> $stable(dac_code);
  endproperty
  property p_sdo_quiet;
    s_link_idle |-> $stable(sdo);
  endproperty
  ////////////////////////////////////////////////////////////
  a_rst_mon: assert property (p_rst_mon) else $error("mux reset value wrong");
  a_rst_dac: assert property (p_rst_dac) else $error("dac reset value wrong");
  a_onehot: assert property (p_onehot) else $error("source not one-hot");
  a_src_frame: assert property (p_src_frame) else $error("source moved mid-frame");
  a_oe_frame: assert property (p_oe_frame) else $error("enable moved mid-frame");
  a_ch_frame: assert property (p_ch_frame) else $error("channel moved mid-frame");
  a_dac_quiet: assert property (p_dac_quiet) else $error("dac moved while idle");
  a_sdo_quiet: assert property (p_sdo_quiet) else $error("sdo moved while idle");
endmodule

bind dmt_top dmt_props u_props (
  .clock                 (clock),
  .rst                   (rst),
  .sclk                  (sclk),
  .cs_n                  (cs_n),
  .toggle_pins           (toggle_pins),
  .sdo                   (sdo),
  .monitor_output_enable (monitor_output_enable),
  .monitor_source        (monitor_source),
  .monitor_channel       (monitor_channel),
  .dac_code              (dac_code)
);

// [sim/dmt_host.sv]
// Purpose: Host controller model for the serial command link
// Assumes: Mode 0, 160 ns serial period, called at a clock edge
// Notes:   sclk parks low and sdi flips between frames
`timescale 1ns/1ps
module dmt_host (
  input  wire logic clock,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // Whole 32-bit frame, MSB first; answer bit taken before each fall
  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    cs_n <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      sdi <= w[i];
      repeat (4) @(posedge clock);
      sclk <= 1'b1;
      repeat (4) @(posedge clock);
      r[i] = sdo;
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clock);
    cs_n <= 1'b1;
    sdi  <= ~w[0];
    repeat (8) @(posedge clock);
  endtask
endmodule

// [sim/dac_monitor_mux_and_toggle_tb_top.sv]
// Purpose: Self-checking bench for the monitor mux and toggle block
// Assumes: Outputs settled 8 clocks after a frame closes
// Notes:   Toggle checks wait 5 clocks for the pin sync chain
`timescale 1ns/1ps
module dac_monitor_mux_and_toggle_tb_top;
  logic             clock;
  logic             rst;
  logic             sclk;
  logic             cs_n;
  logic             sdi;
  logic             sdo;
  logic             oe;
  logic [2:0]       toggle_pins;
  logic [2:0]       chan;
  logic [5:0]       src;
  logic [7:0][15:0] dac_code;
  logic [31:0]      rd;
  int               n_errors;
  int               checks_done;
  logic [15:0]      mux_d [7] = '{16'h0500, 16'h0506, 16'h040e, 16'h0600, 16'h0410, 16'h0420, 16'h0430};
  logic [5:0]       exp_s [7] = '{6'h01, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  dmt_top uut (.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .toggle_pins(toggle_pins),
    .sdo(sdo), .monitor_output_enable(oe), .monitor_source(src), .monitor_channel(chan), .dac_code(dac_code));
  dmt_host host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] d);
    host.xfer({c, d, 8'h00}, rd);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog: a hang counts as a failure
  initial begin
    repeat (30000) @(posedge clock);
    n_errors++;
    close_out();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    toggle_pins = 3'h0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    chk("mon_en", 32'h0, 32'(oe));
    chk("mon_src", 32'h02, 32'(src));
    for (int i = 0; i < 7; i++) begin
      cmd(8'h75, mux_d[i]);
      chk("mon_en", 32'(mux_d[i][10]), 32'(oe));
      chk("mon_src", 32'(exp_s[i]), 32'(src));
      chk("mon_ch", 32'(mux_d[i][3:1]), 32'(chan));
    end
    cmd(8'hd0, 16'h0000);
    chk("rd_now", 32'h0, rd);
    cmd(8'hd0, 16'h0000);
    chk("rd_next", 32'h00043000, rd);
    cmd(8'h75, 16'h0000);
    chk("mon_off", 32'h0, 32'(oe));
    // Code A 0x2000, code B 0x1fff on channel 0; channel 1 gets code A only
    cmd(8'h90, 16'h0000);
    cmd(8'h00, 16'h2000);
    cmd(8'h90, 16'h0001);
    cmd(8'h00, 16'h1fff);
    cmd(8'h01, 16'h1234);
    cmd(8'hb0, 16'h0001);
    for (int s = 0; s < 4; s++) begin
      cmd(8'h10, 16'(s << 4));
      for (int l = 1; l >= 0; l--) begin
        if (s == 0) cmd(8'hc0, 16'(l));
        else toggle_pins <= 3'(l << (s - 1));
        repeat (5) @(posedge clock);
        chk("dac0", l ? 32'h2000 : 32'h1fff, 32'(dac_code[0]));
      end
    end
    chk("dac1", 32'h1234, 32'(dac_code[1]));
    // Address bit 3 set: must not reach code B of channel 0
    cmd(8'h08, 16'hffff);
    cmd(8'h10, 16'h0070);
    chk("dither", 32'h2000, 32'(dac_code[0]));
    cmd(8'h10, 16'h0030);
    chk("dac0_b", 32'h1fff, 32'(dac_code[0]));
    cmd(8'hb0, 16'h0000);
    chk("off", 32'h2000, 32'(dac_code[0]));
    // Second reset in mid-run, mux enabled beforehand
    cmd(8'h75, 16'h0506);
    chk("mon_en", 32'h1, 32'(oe));
    rst <= 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    chk("rst_en", 32'h0, 32'(oe));
    chk("rst_src", 32'h02, 32'(src));
    chk("rst_ch", 32'h0, 32'(chan));
    chk("rst_dac0", 32'h0, 32'(dac_code[0]));
    cmd(8'hd0, 16'h0000);
    cmd(8'hd0, 16'h0000);
    chk("rd_rst", 32'h0, rd);
    close_out();
  end
endmodule
